// ===== rtl/udma_pkg.sv
// Constants shared by the UART DMA request block
`default_nettype none
package udma_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          FIFO_DEPTH    = 16;
  localparam logic [7:0]  FCR_OFF       = 8'h00;
  localparam logic [7:0]  IER_OFF       = 8'h04;
  localparam logic [7:0]  STAT_OFF      = 8'h08;
  localparam int          FCR_FIFO_BIT  = 0;
  localparam int          FCR_MODE_BIT  = 3;
  localparam int          FCR_TET_LSB   = 4;
  localparam int          FCR_RT_LSB    = 6;
  localparam int          IER_THR_BIT   = 7;
  localparam logic [7:0]  FCR_RST       = 8'h00;
  localparam logic [7:0]  IER_RST       = 8'h00;
  localparam int          ST_TX_REQ     = 0;
  localparam int          ST_RX_REQ     = 1;
  localparam int          ST_MODE1      = 2;
  localparam int          ST_THR        = 3;
  localparam int          ST_FIFO       = 4;
  localparam int          ST_TXLVL_LSB  = 8;
  localparam int          ST_RXLVL_LSB  = 16;
  localparam logic [1:0]  TET_EMPTY     = 2'h0;
  localparam logic [1:0]  TET_TWO       = 2'h1;
  localparam logic [1:0]  TET_QUARTER   = 2'h2;
  localparam logic [1:0]  TET_HALF      = 2'h3;
  localparam logic [1:0]  RT_ONE        = 2'h0;
  localparam logic [1:0]  RT_QUARTER    = 2'h1;
  localparam logic [1:0]  RT_HALF       = 2'h2;
  localparam logic [1:0]  RT_NEAR_FULL  = 2'h3;
  localparam int          TET_TWO_LVL   = 2;
  localparam int          RT_ONE_LVL    = 1;
  localparam int          RT_FULL_GAP   = 2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : udma_pkg
`default_nettype wire

// ===== rtl/udma_req_chan.sv
// One DMA request channel with level or acknowledge handshake
`default_nettype none
module udma_req_chan #(
  parameter bit ACK_HS = 1'b0
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_cond,
  input  wire logic clr_cond,
  input  wire logic ack_n,
  output logic      req_n
);
  logic req_n_q;
  logic req_n_d;
  logic hold_q;
  logic hold_d;

  always_comb begin
    req_n_d = req_n_q;
    hold_d  = hold_q;
    if (ACK_HS) begin
      if (!ack_n) begin
        // Acknowledge ends the request and blocks it
        req_n_d = 1'b1;  // see R11
        hold_d  = 1'b1;  // see R19
      end else if (hold_q || req_n_q) begin
        hold_d  = 1'b0;
        req_n_d = !set_cond;  // see R19
      end
    end else if (set_cond) begin
      req_n_d = 1'b0;
    end else if (clr_cond) begin
      req_n_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_n_q <= 1'b1;  // see R22
      hold_q  <= 1'b0;
    end else begin
      req_n_q <= req_n_d;  // see R23
      hold_q  <= hold_d;
    end
  end

  assign req_n = req_n_q;
endmodule : udma_req_chan
`default_nettype wire

// ===== rtl/udma_dma_req.sv
// UART DMA request generator with AHB-Lite register slave
//
// Operation
// R1: Two DMA modes, FIFO control bit 3
// R2: Separate transmit and receive active-low requests
// R3: Mode 0 transmit requests on empty/threshold
// R4: Mode 0 transmit drops after write/above threshold
// R5: Mode 0 receive requests while data held
// R6: Mode 1 transmit requests on empty/threshold
// R7: Mode 1 transmit holds until FIFO full
// R8: Mode 1 receive on trigger or timeout
// R9: Handshake transmit uses mode 0 conditions
// R10: Handshake receive on data or trigger level
// R11: Handshake requests removed by acknowledge
// R12: Handshake ignores DMA mode bit
// R13: Controller uses byte item width both sides
// R14: Transmit request at or below trigger level
// R15: Controller splits blocks into bursts, singles
// R16: Trigger code 01 is 2, 10 is 4
// R17: Receive code 01 selects quarter full
// R18: Burst length should equal depth minus watermark; the controller model uses a fixed burst of 4
// R19: Request held off until acknowledge released
// R20: Four transmit threshold settings
// R21: Threshold mode needs FIFOs, option, enable bit
// R22: Requests inactive after reset
// R23: Requests evaluated synchronously, driven from flops
`default_nettype none
module udma_dma_req #(
  parameter int FIFO_DEPTH = udma_pkg::FIFO_DEPTH,
  parameter bit FIFO_IMPL  = 1'b1,
  parameter bit THR_IMPL   = 1'b1,
  parameter bit ACK_HS     = 1'b0,
  parameter int LVL_W      = $clog2(FIFO_DEPTH) + 1
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [udma_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  input  wire logic [LVL_W-1:0]           tx_fifo_level,
  input  wire logic [LVL_W-1:0]           rx_fifo_level,
  input  wire logic                       thr_empty,
  input  wire logic                       rbr_full,
  input  wire logic                       char_timeout,
  input  wire logic                       dma_tx_ack_n,
  input  wire logic                       dma_rx_ack_n,
  output logic                            dma_tx_req_n,
  output logic                            dma_rx_req_n,
  output logic                            fifo_enable
);

  // Register state
  logic [7:0]                  fifo_control_register_q;
  logic [7:0]                  irq_enable_register_q;
  logic [udma_pkg::ADDR_W-1:0] addr_q;
  logic                        wr_q;
  logic                        act_q;
  logic [31:0]                 hrdata_q;
  logic [31:0]                 hrdata_d;

  // Bus decode
  wire                         take;
  wire                         wr_fcr;
  wire                         wr_ier;
  wire                         rd_fcr;
  wire                         rd_ier;
  wire                         rd_stat;
  wire [31:0]                  status;

  // Configuration decode
  wire                         fifo_on;
  wire                         thr_mode;
  wire                         mode1;
  wire [1:0]                   tet_code;
  wire [1:0]                   rt_code;
  logic [LVL_W-1:0]            tet_level;
  logic [LVL_W-1:0]            rx_trig_level;

  // Level conditions
  wire                         tx_low;
  wire                         tx_full;
  wire                         rx_has;
  wire                         rx_at_trig;

  // Channel conditions
  wire                         tx_set;
  wire                         tx_clr;
  wire                         rx_set;
  wire                         rx_clr;

  // Address phase capture
  assign take    = hsel & hready & htrans[1];
  assign wr_fcr  = act_q & wr_q & (addr_q == udma_pkg::FCR_OFF);
  assign wr_ier  = act_q & wr_q & (addr_q == udma_pkg::IER_OFF);
  assign rd_fcr  = haddr == udma_pkg::FCR_OFF;
  assign rd_ier  = haddr == udma_pkg::IER_OFF;
  assign rd_stat = haddr == udma_pkg::STAT_OFF;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      wr_q   <= 1'b0;
      act_q  <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q   <= hwrite;
      act_q  <= take;
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_control_register_q <= udma_pkg::FCR_RST;
    end else if (wr_fcr) begin
      fifo_control_register_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_register_q <= udma_pkg::IER_RST;
    end else if (wr_ier) begin
      irq_enable_register_q <= hwdata[7:0];
    end
  end

  // Read data, unmapped reads as zero
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (take && !hwrite) begin
      if (rd_fcr) begin
        hrdata_d = {24'h00_0000, fifo_control_register_q};
      end else if (rd_ier) begin
        hrdata_d = {24'h00_0000, irq_enable_register_q};
      end else if (rd_stat) begin
        hrdata_d = status;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (hready) begin
      hrdata_q <= hrdata_d;
    end
  end

  // Status word
  assign status = (32'(!dma_tx_req_n) << udma_pkg::ST_TX_REQ)
                | (32'(!dma_rx_req_n) << udma_pkg::ST_RX_REQ)
                | (32'(mode1) << udma_pkg::ST_MODE1)
                | (32'(thr_mode) << udma_pkg::ST_THR)
                | (32'(fifo_on) << udma_pkg::ST_FIFO)
                | (32'(tx_fifo_level) << udma_pkg::ST_TXLVL_LSB)
                | (32'(rx_fifo_level) << udma_pkg::ST_RXLVL_LSB);

  // Mode selection
  assign fifo_on     = FIFO_IMPL & fifo_control_register_q[udma_pkg::FCR_FIFO_BIT];
  assign fifo_enable = fifo_on;
  assign thr_mode    = fifo_on & THR_IMPL
                     & irq_enable_register_q[udma_pkg::IER_THR_BIT];  // see R21
  assign mode1       = !ACK_HS & fifo_on
                     & fifo_control_register_q[udma_pkg::FCR_MODE_BIT];  // see R1 R12
  assign tet_code    = fifo_control_register_q[udma_pkg::FCR_TET_LSB +: 2];
  assign rt_code     = fifo_control_register_q[udma_pkg::FCR_RT_LSB +: 2];

  // Transmit threshold decode
  always_comb begin
    unique case (tet_code)
      udma_pkg::TET_EMPTY:   tet_level = '0;  // see R20
      udma_pkg::TET_TWO:     tet_level = LVL_W'(udma_pkg::TET_TWO_LVL);  // see R16
      udma_pkg::TET_QUARTER: tet_level = LVL_W'(FIFO_DEPTH / 4);  // see R16
      udma_pkg::TET_HALF:    tet_level = LVL_W'(FIFO_DEPTH / 2);  // see R20
    endcase
  end

  // Receive trigger decode
  always_comb begin
    unique case (rt_code)
      udma_pkg::RT_ONE:       rx_trig_level = LVL_W'(udma_pkg::RT_ONE_LVL);
      udma_pkg::RT_QUARTER:   rx_trig_level = LVL_W'(FIFO_DEPTH / 4);  // see R17
      udma_pkg::RT_HALF:      rx_trig_level = LVL_W'(FIFO_DEPTH / 2);
      udma_pkg::RT_NEAR_FULL: rx_trig_level = LVL_W'(FIFO_DEPTH - udma_pkg::RT_FULL_GAP);
    endcase
  end

  // Transmit low: holding reg empty, FIFO empty, or at/below threshold
  assign tx_low = !fifo_on ? thr_empty
                : thr_mode ? (tx_fifo_level <= tet_level)  // see R14
                : (tx_fifo_level == '0);  // see R3 R9
  assign tx_full    = tx_fifo_level == LVL_W'(FIFO_DEPTH);
  assign rx_has     = fifo_on ? (rx_fifo_level != '0) : rbr_full;
  assign rx_at_trig = rx_fifo_level >= rx_trig_level;

  // Per-mode set and clear terms
  assign tx_set = tx_low;  // see R3 R6 R9
  assign tx_clr = mode1 ? tx_full : !tx_low;  // see R4 R7
  assign rx_set = ACK_HS ? (fifo_on ? rx_at_trig : rbr_full)  // see R10
                : mode1 ? (rx_at_trig | char_timeout)  // see R8
                : rx_has;  // see R5
  assign rx_clr = mode1 ? (rx_fifo_level == '0) : !rx_has;  // see R5 R8

  // Transmit and receive channels
  udma_req_chan #(
    .ACK_HS   (ACK_HS)
  ) u_tx_chan (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_cond (tx_set),
    .clr_cond (tx_clr),
    .ack_n    (dma_tx_ack_n),
    .req_n    (dma_tx_req_n)  // see R2
  );

  udma_req_chan #(
    .ACK_HS   (ACK_HS)
  ) u_rx_chan (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_cond (rx_set),
    .clr_cond (rx_clr),
    .ack_n    (dma_rx_ack_n),
    .req_n    (dma_rx_req_n)  // see R2
  );

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic first_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  property p_reset_idle;
    first_q |-> dma_tx_req_n && dma_rx_req_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle)  // see R22
    else $error("request active right after reset");

  property p_tx_m0_set;
    !ACK_HS && !mode1 && tx_low |=> !dma_tx_req_n;
  endproperty
  a_tx_m0_set: assert property (p_tx_m0_set)  // see R3
    else $error("mode 0 transmit request missing");

  property p_tx_m0_clr;
    !ACK_HS && !mode1 && !tx_low |=> dma_tx_req_n;
  endproperty
  a_tx_m0_clr: assert property (p_tx_m0_clr)  // see R4
    else $error("mode 0 transmit request not removed");

  property p_rx_m0;
    !ACK_HS && !mode1 |-> ##1 (dma_rx_req_n == !$past(rx_has));
  endproperty
  a_rx_m0: assert property (p_rx_m0)  // see R5
    else $error("mode 0 receive request wrong");

  property p_tx_m1_hold;
    mode1 && !dma_tx_req_n && !tx_full && $stable(mode1) |=> !dma_tx_req_n;
  endproperty
  a_tx_m1_hold: assert property (p_tx_m1_hold)  // see R7
    else $error("mode 1 transmit request dropped early");

  property p_tx_m1_clr;
    mode1 && tx_full && !tx_low |=> dma_tx_req_n;
  endproperty
  a_tx_m1_clr: assert property (p_tx_m1_clr)  // see R7
    else $error("mode 1 transmit request not removed at full");

  property p_rx_m1;
    mode1 && (rx_at_trig || char_timeout) |=> !dma_rx_req_n;
  endproperty
  a_rx_m1: assert property (p_rx_m1)  // see R8
    else $error("mode 1 receive request missing");

  property p_ack_drop;
    ACK_HS && !dma_tx_ack_n |=> dma_tx_req_n;
  endproperty
  a_ack_drop: assert property (p_ack_drop)  // see R11
    else $error("transmit request kept during acknowledge");

  property p_ack_release;
    ACK_HS && !dma_rx_ack_n ##1 dma_rx_ack_n |-> dma_rx_req_n;
  endproperty
  a_ack_release: assert property (p_ack_release)  // see R19
    else $error("receive request back before acknowledge release seen");

  property p_tet_decode;
    fifo_on && tet_code == udma_pkg::TET_TWO |-> tet_level == LVL_W'(2);
  endproperty
  a_tet_decode: assert property (p_tet_decode)  // see R16
    else $error("threshold code 01 not decoded to 2");

  c_tx_mode0: cover property (!mode1 && $fell(dma_tx_req_n));
  c_tx_mode1: cover property (mode1 && !dma_tx_req_n ##1 dma_tx_req_n);
  c_rx_timeout: cover property (mode1 && char_timeout && !rx_at_trig ##1 !dma_rx_req_n);
  c_back2back: cover property (!dma_tx_ack_n ##1 dma_tx_ack_n ##1 !dma_tx_req_n);

endmodule : udma_dma_req
`default_nettype wire

// ===== verif/udma_dma_ctl_model.sv
// Behavioural DMA controller channel answering one request line
`default_nettype none
module udma_dma_ctl_model #(
  parameter int BLOCK_ITEMS = 15,
  parameter int BURST       = 4
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       go,
  input  wire logic [3:0] lat,
  input  wire logic       req_n,
  output logic            ack_n,
  output logic [7:0]      items_left
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ITEM_W = 3'h0; // Byte items both sides
  logic [3:0] wait_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_n      <= 1'b1;
      wait_q     <= 4'h0;
      items_left <= 8'(BLOCK_ITEMS);
    end else if (!ack_n) begin
      if (req_n) begin
        ack_n <= 1'b1; // Ack held until request withdrawn
      end
    end else if (go && !req_n && items_left != 8'h00) begin
      if (wait_q == lat) begin
        ack_n  <= 1'b0;
        wait_q <= 4'h0;
        // Bursts first, singles for the remainder
        items_left <= (items_left >= 8'(BURST)) ? items_left - 8'(BURST) : items_left - 8'h01;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : udma_dma_ctl_model
`default_nettype wire

// ===== verif/testbench.sv
// Testbench for the UART DMA request block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, thr_empty, rbr_full, char_timeout, go;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd_s, q;
  logic [4:0]  tx_lvl, rx_lvl;
  logic        hready, hresp, tx_n, rx_n, fifo_on, hs_tx_n, hs_rx_n, tx_ack_n, rx_ack_n;
  logic [7:0]  tx_left, rx_left;
  logic [4:0]  trig [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
  int          err_total, checks_done;

  udma_dma_req DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .tx_fifo_level(tx_lvl),
    .rx_fifo_level(rx_lvl), .thr_empty(thr_empty), .rbr_full(rbr_full),
    .char_timeout(char_timeout), .dma_tx_ack_n(1'b1), .dma_rx_ack_n(1'b1),
    .dma_tx_req_n(tx_n), .dma_rx_req_n(rx_n), .fifo_enable(fifo_on));
  udma_dma_req #(.ACK_HS(1'b1)) DUT_HS (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(), .hresp(), .hrdata(), .tx_fifo_level(tx_lvl),
    .rx_fifo_level(rx_lvl), .thr_empty(thr_empty), .rbr_full(rbr_full),
    .char_timeout(char_timeout), .dma_tx_ack_n(tx_ack_n), .dma_rx_ack_n(rx_ack_n),
    .dma_tx_req_n(hs_tx_n), .dma_rx_req_n(hs_rx_n), .fifo_enable());
  udma_dma_ctl_model tx_ctl (.hclk(hclk), .hresetn(hresetn), .go(go), .lat(4'h3),
    .req_n(hs_tx_n), .ack_n(tx_ack_n), .items_left(tx_left));
  udma_dma_ctl_model rx_ctl (.hclk(hclk), .hresetn(hresetn), .go(go), .lat(4'h0),
    .req_n(hs_rx_n), .ack_n(rx_ack_n), .items_left(rx_left));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) rd_s <= hrdata;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= udma_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    #1;
    q = rd_s;
  endtask : bus

  task automatic cfg(input logic [7:0] f, input logic [7:0] i);
    bus(1'b1, udma_pkg::FCR_OFF, {24'h0, f});
    bus(1'b1, udma_pkg::IER_OFF, {24'h0, i});
  endtask : cfg

  task automatic lv(input logic [4:0] t, input logic [4:0] r, input logic te,
                    input logic rb, input logic to);
    @(posedge hclk);
    tx_lvl <= t;
    rx_lvl <= r;
    thr_empty <= te;
    rbr_full <= rb;
    char_timeout <= to;
    @(posedge hclk);
    #1;
  endtask : lv

  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  initial begin
    {hresetn, hsel, hwrite, thr_empty, rbr_full, char_timeout, go} = 7'h0;
    {haddr, htrans, hsize, hwdata, tx_lvl, rx_lvl} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    lv(5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b1);
    chk(rx_n, 1'b1);
    bus(1'b0, udma_pkg::FCR_OFF, 32'h0);
    chk(q, {24'h0, udma_pkg::FCR_RST});
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    cfg(8'h08, 8'h80);
    bus(1'b0, udma_pkg::STAT_OFF, 32'h0);
    chk(q[4:2], 3'h0);
    lv(5'h00, 5'h00, 1'b1, 1'b1, 1'b0);
    chk(tx_n, 1'b0);
    chk(rx_n, 1'b0);
    lv(5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b1);
    chk(rx_n, 1'b1);
    cfg(8'h21, 8'h00);
    chk(fifo_on, 1'b1);
    lv(5'h04, 5'h01, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b1);
    chk(rx_n, 1'b0);
    lv(5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b0);
    chk(rx_n, 1'b1);
    for (int c = 0; c < 4; c++) begin
      cfg({2'h0, 2'(c), 4'h1}, 8'h80);
      lv(trig[c], 5'h00, 1'b0, 1'b0, 1'b0);
      chk(tx_n, 1'b0);
      lv(trig[c] + 5'h01, 5'h00, 1'b0, 1'b0, 1'b0);
      chk(tx_n, 1'b1);
    end
    cfg(8'h49, 8'h00);
    bus(1'b0, udma_pkg::STAT_OFF, 32'h0);
    chk(q[2], 1'b1);
    lv(5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b0);
    lv(5'h05, 5'h03, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b0);
    chk(rx_n, 1'b1);
    lv(5'h10, 5'h04, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b1);
    chk(rx_n, 1'b0);
    lv(5'h05, 5'h01, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b1);
    chk(rx_n, 1'b0);
    lv(5'h05, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(rx_n, 1'b1);
    lv(5'h05, 5'h01, 1'b0, 1'b0, 1'b1);
    chk(rx_n, 1'b0);
    cfg(8'h69, 8'h80);
    lv(5'h04, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(tx_n, 1'b0);
    @(posedge hclk);
    go <= 1'b1;
    lv(5'h00, 5'h04, 1'b0, 1'b0, 1'b0);
    repeat (120) @(posedge hclk);
    #1;
    chk(tx_left, 8'h00);
    chk(rx_left, 8'h00);
    chk(hs_tx_n, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    go      <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(tx_n, 1'b1);
    chk(hs_tx_n, 1'b1);
    chk(hs_rx_n, 1'b1);
    bus(1'b0, udma_pkg::FCR_OFF, 32'h0);
    chk(q, {24'h0, udma_pkg::FCR_RST});
    chk(tx_n, 1'b1);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
